//--- hdl/plc_pkg.sv
// Purpose: Shared constants, types and functions of the logic combiner.
// Assumes: 20 MHz clock, delays kept as counts of tenth-second ticks.
// Notes: Register addresses are word indexes on the plain register port.
package plc_pkg;

  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_TIME_NS = 100000000;
  localparam int unsigned TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W = 22;

  // Delay counts in tenths, up to 9:59:59.9.
  localparam int unsigned DLY_W = 19;
  localparam logic [18:0] DLY_MAX = 19'h57e3f;

  // Register map.
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] LF_CFG_BASE = 6'h00;
  localparam logic [5:0] LF_SRC_BASE = 6'h04;
  localparam logic [5:0] LF_VIEW_BASE = 6'h08;
  localparam logic [5:0] DC_SEL_BASE = 6'h0c;
  localparam logic [5:0] DC_SET_BASE = 6'h10;
  localparam logic [5:0] DC_CLR_BASE = 6'h14;
  localparam logic [5:0] DC_CNT_BASE = 6'h18;

  // Field positions.
  localparam int unsigned CFG_OP1_POS = 0;
  localparam int unsigned CFG_OP2_POS = 2;
  localparam int unsigned CFG_OP3_POS = 4;
  localparam int unsigned CFG_ORDER_POS = 6;
  localparam int unsigned VIEW_RESULT_POS = 7;
  localparam int unsigned SRC_FIELD_STRIDE = 8;

  // Logic input source codes.
  localparam logic [5:0] SRC_CA1 = 6'h00;
  localparam logic [5:0] SRC_CA2_N = 6'h03;
  localparam logic [5:0] SRC_CA3 = 6'h04;
  localparam logic [5:0] SRC_CA4 = 6'h06;
  localparam logic [4:0] SRC_LOGIC_PAIR = 5'h08;
  localparam logic [5:0] SRC_MAX = 6'h2b;

  // Digital comparator condition codes.
  localparam logic [2:0] DC_SRC_OPERATION = 3'h0;
  localparam logic [2:0] DC_SRC_DIGIN1 = 3'h1;
  localparam logic [2:0] DC_SRC_TRIP = 3'h2;
  localparam logic [2:0] DC_SRC_READY = 3'h3;

  typedef logic [18:0] plc_dly_t;
  typedef logic [5:0] plc_src_t;

  typedef enum logic [1:0] {
    OP_END = 2'h0,
    OP_AND = 2'h1,
    OP_OR = 2'h2,
    OP_XOR = 2'h3
  } plc_op_t;

  typedef enum logic [0:0] {
    ORD_CHAIN = 1'h0,
    ORD_PAIRS = 1'h1
  } plc_order_t;

  typedef enum logic [1:0] {
    DC_IDLE = 2'b00,
    DC_SETTING = 2'b01,
    DC_ACTIVE = 2'b11,
    DC_CLEARING = 2'b10
  } plc_dc_state_t;

  typedef struct packed {
    plc_order_t order;
    plc_op_t op3;
    plc_op_t op2;
    plc_op_t op1;
    plc_src_t [3:0] sel;
  } plc_lf_cfg_t;

  typedef struct packed {
    logic [2:0] sel;
    plc_dly_t set_dly;
    plc_dly_t clr_dly;
  } plc_dc_cfg_t;

  function automatic logic plc_op_apply(plc_op_t op, logic a, logic b);
    case (op)
      OP_AND: plc_op_apply = a & b;
      OP_OR: plc_op_apply = a | b;
      OP_XOR: plc_op_apply = a ^ b;
      default: plc_op_apply = a;
    endcase
  endfunction : plc_op_apply

  function automatic logic plc_pick_src(logic [21:0] vec, plc_src_t code);
    plc_pick_src = vec[code[5:1]] ^ code[0];
  endfunction : plc_pick_src

  function automatic logic plc_src_allowed(logic [1:0] lf, plc_src_t code);
    plc_src_allowed = (code <= SRC_MAX) &&
                      (code[5:1] != (SRC_LOGIC_PAIR + {3'h0, lf}));
  endfunction : plc_src_allowed

  function automatic plc_dly_t plc_clamp(logic [31:0] v);
    plc_clamp = (v > {13'h0, DLY_MAX}) ? DLY_MAX : v[18:0];
  endfunction : plc_clamp

endpackage : plc_pkg

//--- hdl/plc_dcmp.sv
// Purpose: One digital comparator with set and clear delay timers.
// Assumes: tick is a one-cycle pulse every tenth of a second.
// Notes: Delays above the maximum are clamped before they arrive here.
`timescale 1ns/1ps
module plc_dcmp
  import plc_pkg::*;
(
  // Clock and control.
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic tick,
  // Condition and delays.
  input wire logic in_level,
  input wire plc_dly_t set_dly,
  input wire plc_dly_t clr_dly,
  // Result.
  output logic out_q,
  output plc_dly_t cnt_q
);

  plc_dc_state_t state_q;
  plc_dc_state_t state_d;
  plc_dly_t cnt_d;
  logic out_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    out_d = out_q;
    case (state_q)
      DC_IDLE: begin
        if (in_level) begin
          cnt_d = '0;
          if (set_dly == '0) begin
            state_d = DC_ACTIVE;
            out_d = 1'b1;
          end else begin
            state_d = DC_SETTING;
          end
        end
      end
      DC_SETTING: begin
        if (!in_level) begin
          state_d = DC_IDLE;
          cnt_d = '0;
        end else if (cnt_q >= set_dly) begin
          state_d = DC_ACTIVE;
          out_d = 1'b1;
          cnt_d = '0;
        end else if (tick) begin
          cnt_d = cnt_q + 19'h1;
        end
      end
      DC_ACTIVE: begin
        if (!in_level) begin
          cnt_d = '0;
          if (clr_dly == '0) begin
            state_d = DC_IDLE;
            out_d = 1'b0;
          end else begin
            state_d = DC_CLEARING;
          end
        end
      end
      DC_CLEARING: begin
        if (in_level) begin
          state_d = DC_ACTIVE;
          cnt_d = '0;
        end else if (cnt_q >= clr_dly) begin
          state_d = DC_IDLE;
          out_d = 1'b0;
          cnt_d = '0;
        end else if (tick) begin
          cnt_d = cnt_q + 19'h1;
        end
      end
      default: begin
        state_d = DC_IDLE;
        out_d = 1'b0;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= DC_IDLE;
      out_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      out_q <= out_d;
    end
  end

  // The live count stays visible so software can watch a delay run out.
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_release;
    ce && state_q == DC_ACTIVE && !in_level && clr_dly != '0;
  endsequence

  a_clear_hold: assert property (s_release |=> out_q &&
                                 state_q == DC_CLEARING)
    else $error("Output dropped before its clear delay.");

  a_clear_zero: assert property (ce && state_q == DC_ACTIVE &&
                                 !in_level && clr_dly == '0 |=> !out_q)
    else $error("Output held with zero clear delay.");

  a_set_zero: assert property (ce && state_q == DC_IDLE &&
                               in_level && set_dly == '0 |=> out_q)
    else $error("Output not raised with zero set delay.");

  a_cnt_bound: assert property (cnt_q <= DLY_MAX)
    else $error("Delay count beyond its range.");

  a_tick_only: assert property (ce && !tick |=>
                                cnt_q == $past(cnt_q) || cnt_q == '0)
    else $error("Delay count moved without a tick.");

  a_ce_freeze: assert property (!ce |=> $stable(out_q) && $stable(cnt_q))
    else $error("State changed while the clock enable was low.");

endmodule : plc_dcmp

//--- hdl/plc_top.sv
// Purpose: Four logic combiners and four delayed digital comparators.
// Assumes: All inputs are synchronous to clk; one register port master.
// Notes: Logic results are registered, so feedback between them is safe.
`timescale 1ns/1ps
module plc_top
  import plc_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  // Clock and control.
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Register port.
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_q,
  // Sources from the rest of the controller.
  input wire logic [3:0] analog_cmp_out,
  input wire logic [3:0] timer_out,
  input wire logic [3:0] flipflop_out,
  input wire logic [1:0] counter_out,
  input wire logic [7:0] dc_cond,
  // Results.
  output logic [3:0] digital_cmp_out,
  output logic [3:0] logic_result_q
);

  plc_lf_cfg_t [3:0] lf_cfg_q;
  plc_dc_cfg_t [3:0] dc_cfg_q;
  plc_dly_t [3:0] dc_cnt;
  logic [21:0] src_vec;
  logic [3:0][3:0] opnd;
  logic [3:0] eval_d;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick;

  // Tenth-second tick shared by all delay timers.
  assign tick = ce && (tick_cnt_q == TICK_W'(TICK_CYC - 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      tick_cnt_q <= '0;
    end else if (ce) begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 22'h1;
    end
  end

  // Source bank in code order, two codes per signal.
  assign src_vec = {counter_out, flipflop_out, timer_out,
                    logic_result_q, digital_cmp_out, analog_cmp_out};

  function automatic logic lf_eval(plc_lf_cfg_t c, logic [3:0] o);
    logic l;
    logic r;
    l = (c.op1 == OP_END) ? o[0] : plc_op_apply(c.op1, o[0], o[1]);
    if (c.order == ORD_PAIRS) begin
      r = (c.op3 == OP_END) ? o[2] : plc_op_apply(c.op3, o[2], o[3]);
      lf_eval = (c.op1 == OP_END || c.op2 == OP_END) ? l :
                plc_op_apply(c.op2, l, r);
    end else begin
      if (c.op1 != OP_END && c.op2 != OP_END) begin
        l = plc_op_apply(c.op2, l, o[2]);
        if (c.op3 != OP_END) begin
          l = plc_op_apply(c.op3, l, o[3]);
        end
      end
      lf_eval = l;
    end
  endfunction : lf_eval

  for (genvar n = 0; n < 4; n++) begin : g_lf
    for (genvar k = 0; k < 4; k++) begin : g_opnd
      assign opnd[n][k] = plc_pick_src(src_vec, lf_cfg_q[n].sel[k]);
    end
    assign eval_d[n] = lf_eval(lf_cfg_q[n], opnd[n]);
  end

  // One register stage breaks loops through the logic outputs.
  always_ff @(posedge clk) begin
    if (reset) begin
      logic_result_q <= '0;
    end else if (ce) begin
      logic_result_q <= eval_d;
    end
  end

  // Logic function configuration writes.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int n = 0; n < 4; n++) begin
        lf_cfg_q[n].order <= ORD_CHAIN;
        lf_cfg_q[n].op1 <= OP_AND;
        lf_cfg_q[n].op2 <= OP_AND;
        lf_cfg_q[n].op3 <= OP_AND;
        lf_cfg_q[n].sel[0] <= SRC_CA1;
        lf_cfg_q[n].sel[1] <= SRC_CA2_N;
        lf_cfg_q[n].sel[2] <= SRC_CA3;
        lf_cfg_q[n].sel[3] <= SRC_CA4;
      end
    end else if (ce && wr) begin
      for (int n = 0; n < 4; n++) begin
        if (addr == LF_CFG_BASE + 6'(n)) begin
          lf_cfg_q[n].op1 <= plc_op_t'(wdata[CFG_OP1_POS +: 2]);
          lf_cfg_q[n].op2 <= plc_op_t'(wdata[CFG_OP2_POS +: 2]);
          lf_cfg_q[n].op3 <= plc_op_t'(wdata[CFG_OP3_POS +: 2]);
          lf_cfg_q[n].order <= plc_order_t'(wdata[CFG_ORDER_POS]);
        end
        if (addr == LF_SRC_BASE + 6'(n)) begin
          // A refused field keeps its old code; the others still update.
          for (int k = 0; k < 4; k++) begin
            if (plc_src_allowed(2'(n),
                wdata[k*SRC_FIELD_STRIDE +: 6])) begin
              lf_cfg_q[n].sel[k] <= wdata[k*SRC_FIELD_STRIDE +: 6];
            end
          end
        end
      end
    end
  end

  // Digital comparator configuration writes.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int n = 0; n < 4; n++) begin
        dc_cfg_q[n].set_dly <= '0;
        dc_cfg_q[n].clr_dly <= '0;
      end
      dc_cfg_q[0].sel <= DC_SRC_OPERATION;
      dc_cfg_q[1].sel <= DC_SRC_DIGIN1;
      dc_cfg_q[2].sel <= DC_SRC_TRIP;
      dc_cfg_q[3].sel <= DC_SRC_READY;
    end else if (ce && wr) begin
      for (int n = 0; n < 4; n++) begin
        if (addr == DC_SEL_BASE + 6'(n)) begin
          dc_cfg_q[n].sel <= wdata[2:0];
        end
        if (addr == DC_SET_BASE + 6'(n)) begin
          dc_cfg_q[n].set_dly <= plc_clamp(wdata);
        end
        if (addr == DC_CLR_BASE + 6'(n)) begin
          dc_cfg_q[n].clr_dly <= plc_clamp(wdata);
        end
      end
    end
  end

  for (genvar n = 0; n < 4; n++) begin : g_dc
    plc_dcmp u_dcmp (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .tick(tick),
      .in_level(dc_cond[dc_cfg_q[n].sel]),
      .set_dly(dc_cfg_q[n].set_dly),
      .clr_dly(dc_cfg_q[n].clr_dly),
      .out_q(digital_cmp_out[n]),
      .cnt_q(dc_cnt[n])
    );
  end

  // Read port, data one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= '0;
      if (rd) begin
        for (int n = 0; n < 4; n++) begin
          if (addr == LF_CFG_BASE + 6'(n)) begin
            rdata_q <= {25'h0, lf_cfg_q[n].order, lf_cfg_q[n].op3,
                        lf_cfg_q[n].op2, lf_cfg_q[n].op1};
          end
          if (addr == LF_SRC_BASE + 6'(n)) begin
            rdata_q <= {2'h0, lf_cfg_q[n].sel[3], 2'h0, lf_cfg_q[n].sel[2],
                        2'h0, lf_cfg_q[n].sel[1], 2'h0, lf_cfg_q[n].sel[0]};
          end
          if (addr == LF_VIEW_BASE + 6'(n)) begin
            rdata_q <= {24'h0, logic_result_q[n], lf_cfg_q[n].order,
                        lf_cfg_q[n].op3, lf_cfg_q[n].op2, lf_cfg_q[n].op1};
          end
          if (addr == DC_SEL_BASE + 6'(n)) begin
            rdata_q <= {29'h0, dc_cfg_q[n].sel};
          end
          if (addr == DC_SET_BASE + 6'(n)) begin
            rdata_q <= {13'h0, dc_cfg_q[n].set_dly};
          end
          if (addr == DC_CLR_BASE + 6'(n)) begin
            rdata_q <= {13'h0, dc_cfg_q[n].clr_dly};
          end
          if (addr == DC_CNT_BASE + 6'(n)) begin
            rdata_q <= {13'h0, dc_cnt[n]};
          end
        end
      end
    end
  end

  // Helper for the checks below: any function pointing at itself.
  logic self_bad;
  always_comb begin
    self_bad = 1'b0;
    for (int n = 0; n < 4; n++) begin
      for (int k = 0; k < 4; k++) begin
        if (!plc_src_allowed(2'(n), lf_cfg_q[n].sel[k])) begin
          self_bad = 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_no_self_src: assert property (!self_bad)
    else $error("A logic function selects its own output.");

  a_and_chain: assert property (ce && lf_cfg_q[0].order == ORD_CHAIN &&
      lf_cfg_q[0].op1 == OP_AND && lf_cfg_q[0].op2 == OP_AND &&
      lf_cfg_q[0].op3 == OP_AND |=> logic_result_q[0] == $past(&opnd[0]))
    else $error("Chained AND result is wrong.");

  a_pair_order: assert property (ce && lf_cfg_q[0].order == ORD_PAIRS &&
      lf_cfg_q[0].op1 == OP_OR && lf_cfg_q[0].op2 == OP_XOR &&
      lf_cfg_q[0].op3 == OP_OR |=> logic_result_q[0] ==
      $past((opnd[0][0] | opnd[0][1]) ^ (opnd[0][2] | opnd[0][3])))
    else $error("Paired order result is wrong.");

  a_end_marker: assert property (ce && lf_cfg_q[3].op1 == OP_END |=>
      logic_result_q[3] == $past(opnd[3][0]))
    else $error("End marker did not stop the expression.");

  a_read_count: assert property (ce && rd && addr == DC_CNT_BASE |=>
      rdata_q == {13'h0, $past(dc_cnt[0])})
    else $error("Delay count readback is wrong.");

  a_lf_default: assert property ($past(reset) |->
      lf_cfg_q[0].sel[0] == SRC_CA1 && lf_cfg_q[0].sel[1] == SRC_CA2_N &&
      lf_cfg_q[0].op1 == OP_AND)
    else $error("Logic function reset defaults are wrong.");

  a_dc_default: assert property ($past(reset) |->
      dc_cfg_q[1].sel == DC_SRC_DIGIN1 && dc_cfg_q[2].sel == DC_SRC_TRIP &&
      dc_cfg_q[3].sel == DC_SRC_READY)
    else $error("Comparator reset defaults are wrong.");

  a_rd_idle_zero: assert property (ce && !rd |=> rdata_q == '0)
    else $error("Read data stood longer than one cycle.");

  a_ce_hold: assert property (!ce |=> $stable(logic_result_q) &&
      $stable(rdata_q) && $stable(tick_cnt_q))
    else $error("Top state changed while the clock enable was low.");

  a_tick_wrap: assert property (tick |=> tick_cnt_q == '0)
    else $error("Tick counter did not wrap after a tick.");

  a_tick_step: assert property (ce && !tick |=>
      tick_cnt_q == $past(tick_cnt_q) + 22'h1)
    else $error("Tick counter skipped a step.");

  // Refused codes must leave the stored selector untouched.
  sequence s_own_src_wr;
    ce && wr && addr == LF_SRC_BASE + 6'h03 &&
    !plc_src_allowed(2'h3, wdata[5:0]);
  endsequence

  a_src_refused: assert property (s_own_src_wr |=>
      $stable(lf_cfg_q[3].sel[0]))
    else $error("A refused source code was stored.");

  a_clamp_delay: assert property (ce && wr &&
      addr == DC_SET_BASE + 6'h01 && wdata > {13'h0, DLY_MAX} |=>
      dc_cfg_q[1].set_dly == DLY_MAX)
    else $error("An oversized delay was not clamped.");

  a_xor_chain: assert property (ce &&
      lf_cfg_q[0].order == ORD_CHAIN && lf_cfg_q[0].op1 == OP_XOR &&
      lf_cfg_q[0].op2 == OP_XOR && lf_cfg_q[0].op3 == OP_XOR |=>
      logic_result_q[0] == $past(^opnd[0]))
    else $error("Chained XOR result is wrong.");

  a_or_chain: assert property (ce &&
      lf_cfg_q[0].order == ORD_CHAIN && lf_cfg_q[0].op1 == OP_OR &&
      lf_cfg_q[0].op2 == OP_OR && lf_cfg_q[0].op3 == OP_OR |=>
      logic_result_q[0] == $past(|opnd[0]))
    else $error("Chained OR result is wrong.");

  a_view_read: assert property (ce && rd && addr == LF_VIEW_BASE |=>
      rdata_q[VIEW_RESULT_POS] == $past(logic_result_q[0]))
    else $error("View readback lost the result bit.");

endmodule : plc_top

//--- testbench/plc_src_model.sv
// Purpose: Far-side sources of the combiner: comparators, timers, flops.
// Assumes: The bench loads a new source pattern with a one-cycle load.
// Notes: Values change only just after a rising edge, like real flops.
`timescale 1ns/1ps
module plc_src_model (
  // Clock and load.
  input wire logic clk,
  input wire logic reset,
  input wire logic ld,
  input wire logic [21:0] ld_val,
  // Sources toward the combiner.
  output logic [3:0] analog_cmp_out,
  output logic [3:0] timer_out,
  output logic [3:0] flipflop_out,
  output logic [1:0] counter_out,
  output logic [7:0] dc_cond
);
  logic [21:0] src_q;

  // Registered so that the combiner never sees a change at its own edge.
  always_ff @(posedge clk) begin
    if (reset) begin
      src_q <= 22'h0;
    end else if (ld) begin
      src_q <= ld_val;
    end
  end

  assign {dc_cond, counter_out, flipflop_out, timer_out, analog_cmp_out} =
    src_q;
endmodule : plc_src_model

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the logic combiner and comparators.
// Assumes: A tick of four cycles so that delays run quickly.
// Notes: Sources come from the partner model, loaded one edge ahead.
`timescale 1ns/1ps
module testbench;
  import plc_pkg::*;
  localparam int unsigned TK = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ce = 1'b1;
  logic ld = 1'b0;
  logic [21:0] ld_val = 22'h0;
  logic [31:0] rdata_q;
  logic [3:0] analog_cmp_out, timer_out, flipflop_out;
  logic [3:0] digital_cmp_out, logic_result_q;
  logic [1:0] counter_out;
  logic [7:0] dc_cond;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  plc_src_model i_src (
    .clk(clk), .reset(reset), .ld(ld), .ld_val(ld_val),
    .analog_cmp_out(analog_cmp_out), .timer_out(timer_out),
    .flipflop_out(flipflop_out), .counter_out(counter_out),
    .dc_cond(dc_cond)
  );

  plc_top #(.TICK_CYC(TK)) i_dut (
    .clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .analog_cmp_out(analog_cmp_out),
    .timer_out(timer_out), .flipflop_out(flipflop_out),
    .counter_out(counter_out), .dc_cond(dc_cond),
    .digital_cmp_out(digital_cmp_out), .logic_result_q(logic_result_q)
  );

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // The whole run needs roughly seven thousand cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      $display("[ERR] timeout exp finish got hang");
      test_done();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk

  task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input string n, input logic [5:0] a,
                        input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, e, rdata_q);
  endtask : rd_chk

  // Sources land at the second edge, the result must follow at the next.
  task automatic set_src(input logic [21:0] v);
    @(posedge clk);
    ld <= 1'b1;
    ld_val <= v;
    @(posedge clk);
    ld <= 1'b0;
    @(posedge clk);
    #1;
  endtask : set_src

  task automatic wait_cmp(input logic lvl, output int n);
    n = 0;
    while (digital_cmp_out[0] !== lvl && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_cmp

  function automatic logic op2v(logic [1:0] op, logic a, logic b);
    case (op)
      2'h1: op2v = a & b;
      2'h2: op2v = a | b;
      2'h3: op2v = a ^ b;
      default: op2v = a;
    endcase
  endfunction : op2v

  function automatic logic expr(logic [6:0] c, logic [3:0] v);
    logic l;
    logic r;
    l = (c[1:0] == 2'h0) ? v[0] : op2v(c[1:0], v[0], v[1]);
    if (c[6]) begin
      r = (c[5:4] == 2'h0) ? v[2] : op2v(c[5:4], v[2], v[3]);
      expr = (c[1:0] == 2'h0 || c[3:2] == 2'h0) ? l : op2v(c[3:2], l, r);
    end else begin
      expr = l;
      if (c[1:0] != 2'h0 && c[3:2] != 2'h0) begin
        expr = op2v(c[3:2], l, v[2]);
        if (c[5:4] != 2'h0) begin
          expr = op2v(c[5:4], expr, v[3]);
        end
      end
    end
  endfunction : expr

  initial begin
    logic [21:0] ldv;
    logic [21:0] srcv;
    logic e;
    int n;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      rd_chk("cfg", LF_CFG_BASE + 6'(f), 32'h15);
      rd_chk("src", LF_SRC_BASE + 6'(f), 32'h06040300);
      rd_chk("view", LF_VIEW_BASE + 6'(f), 32'h15);
      rd_chk("dsel", DC_SEL_BASE + 6'(f), 32'(f));
      rd_chk("dset", DC_SET_BASE + 6'(f), 32'h0);
      rd_chk("dclr", DC_CLR_BASE + 6'(f), 32'h0);
      rd_chk("dcnt", DC_CNT_BASE + 6'(f), 32'h0);
    end
    rd_chk("unmapped", 6'h3f, 32'h0);
    set_src(22'h0000d);
    chk("res_all", 32'hf, {28'h0, logic_result_q});
    set_src(22'h0000f);
    chk("res_all", 32'h0, {28'h0, logic_result_q});
    // Every order and operator code over every operand pattern.
    reg_wr(LF_SRC_BASE, 32'h1e1c1a18);
    for (int c = 0; c < 128; c++) begin
      reg_wr(LF_CFG_BASE, 32'(c));
      for (int v = 0; v < 16; v++) begin
        set_src(22'(v) << 4);
        e = expr(7'(c), 4'(v));
        chk("lf0", {31'h0, e}, {31'h0, logic_result_q[0]});
      end
      rd_chk("view", LF_VIEW_BASE, {24'h0, e, 7'(c)});
    end
    // Every source code, read back through function four alone.
    reg_wr(LF_CFG_BASE, 32'h15);
    reg_wr(LF_SRC_BASE, 32'h06040300);
    reg_wr(LF_CFG_BASE + 6'h03, 32'h0);
    ldv = {8'h06, 2'b01, 4'h3, 4'ha, 4'hd};
    srcv = {2'b01, 4'h3, 4'ha, 4'h7, 4'h6, 4'hd};
    set_src(ldv);
    repeat (2) @(posedge clk);
    for (int c = 0; c < 44; c++) begin
      reg_wr(LF_SRC_BASE + 6'h03, 32'(c));
      repeat (2) @(posedge clk);
      #1;
      if (c == 22 || c == 23) begin
        rd_chk("own_src", LF_SRC_BASE + 6'h03, 32'h15);
      end else begin
        chk("code", {31'h0, srcv[c / 2] ^ c[0]}, {31'h0, logic_result_q[3]});
      end
    end
    reg_wr(LF_SRC_BASE + 6'h03, 32'h2c);
    rd_chk("range", LF_SRC_BASE + 6'h03, 32'h2b);
    // Delay range saturates at 9:59:59.9 in tenths.
    reg_wr(DC_SET_BASE + 6'h01, 32'h7ffff);
    rd_chk("clamp", DC_SET_BASE + 6'h01, 32'h57e3f);
    reg_wr(DC_SET_BASE + 6'h01, 32'h0);
    reg_wr(DC_SEL_BASE + 6'h03, 32'h4);
    rd_chk("dsel_wr", DC_SEL_BASE + 6'h03, 32'h4);
    // Comparator one: set delay three ticks, clear delay five ticks.
    reg_wr(DC_SET_BASE, 32'h3);
    reg_wr(DC_CLR_BASE, 32'h5);
    set_src(ldv | 22'h004000);
    wait_cmp(1'b1, n);
    chk("set_lo", 32'h1, 32'(n >= 2 * TK));
    chk("set_hi", 32'h1, 32'(n <= 3 * TK + 3));
    rd_chk("cnt_act", DC_CNT_BASE, 32'h0);
    set_src(ldv);
    repeat (2 * TK) @(posedge clk);
    @(posedge clk);
    addr <= DC_CNT_BASE;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("cnt_run", 32'h1, 32'(rdata_q >= 1 && rdata_q <= 3));
    chk("clr_hold", 32'h1, {31'h0, digital_cmp_out[0]});
    wait_cmp(1'b0, n);
    n = n + 2 * TK + 2;
    chk("clr_lo", 32'h1, 32'(n >= 4 * TK));
    chk("clr_hi", 32'h1, 32'(n <= 5 * TK + 3));
    // Clock enable low must freeze the results while the sources move.
    @(posedge clk);
    ce <= 1'b0;
    set_src(ldv ^ 22'h000001);
    chk("ce_hold", 32'hf, {28'h0, logic_result_q});
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    #1;
    chk("ce_run", 32'h8, {28'h0, logic_result_q});
    test_done();
  end
endmodule : testbench
